// >>> ssp_pkg.sv
/*
 * Package for the serial port block: register indices, field positions,
 * reset values, mode codes, clock divider counts and pin carrier structs.
 * Assumes a single 100 MHz system clock domain.
 */
`default_nettype none
package ssp_pkg;
    // Register indices on the plain register port
    localparam logic [1:0] REG_CTRL0 = 2'h0;
    localparam logic [1:0] REG_CTRL2 = 2'h1;
    localparam logic [1:0] REG_DATA  = 2'h2;

    // First control register fields
    localparam int C0_MODE_LSB = 5;
    localparam int C0_DEB_LSB  = 2;
    localparam int C0_EN       = 1;
    localparam int C0_ICF      = 0;
    localparam logic [7:0] C0_RESET = 8'he0;

    // Line control register fields
    localparam int C2_GP_LSB = 6;
    localparam int C2_CKPOL  = 5;
    localparam int C2_CAPTURE_EDGE_SELECT   = 4;
    localparam int C2_MLS    = 3;
    localparam int C2_SELECT_PIN_ENABLE   = 2;
    localparam int C2_WRITE_COLLISION_FLAG   = 1;
    localparam int C2_TRF    = 0;
    localparam logic [7:0] C2_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // Half-period counts of the master clock per mode
    localparam logic [4:0] HALF_DIV4  = 5'h01;
    localparam logic [4:0] HALF_DIV16 = 5'h07;
    localparam logic [4:0] HALF_DIV64 = 5'h1f;
    localparam logic [3:0] BITS_PER_XFER = 4'h8;

    typedef enum logic [2:0] {
        MODE_M4   = 3'b000,
        MODE_M16  = 3'b001,
        MODE_M64  = 3'b010,
        MODE_MSUB = 3'b011,
        MODE_MTMR = 3'b100,
        MODE_SLV  = 3'b101,
        MODE_I2C  = 3'b110,
        MODE_NONE = 3'b111
    } ssp_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LEAD = 2'b01,
        ST_TRAIL = 2'b11
    } ssp_state_t;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic sdo_o;
        logic sdo_oe;
    } ssp_pins_out_t;

    typedef struct packed {
        logic sck_i;
        logic sdi_i;
        logic scs_n_i;
    } ssp_pins_in_t;
endpackage : ssp_pkg
`default_nettype wire

// >>> ssp_port.sv
/*
 * SPI master/slave shift port with its control and data registers.
 * Assumes a one-cycle register port and pin inputs from outside the clock
 * domain; subclock and timer rates arrive as one-cycle enable pulses.
 */
`default_nettype none
// Behaviour
// - Enable bit 0 releases pins and idles logic; 1 runs the port in SPI master and slave modes.
// - Enabling in SPI mode leaves control register contents untouched.
// - Enabling in I2C mode keeps direction bits, resets I2C flags.
// - Slave select rising mid-byte sets incomplete and done flags.
// - Software setting the incomplete flag does not set done.
// - Top two bits of line control are plain storage, reset zero.
// - Polarity bit 0 idles clock high, 1 idles it low.
// - Edge bit with polarity picks the capture edge.
// - Order bit 1 shifts MSB first, 0 LSB first.
// - Select enable 0 ignores select pin; 1 uses it active low.
// - Data write during transfer is dropped and sets collision flag.
// - Hardware sets done at byte end; only software clears it.
// - Master data write starts clock; send and receive together.
// - Slave shifts data out and in on external clock pulses.
// - Port runs while its selected clock source stays active.
// - Enabled idle: input floats, output high, clock per mode.
// - Three-bit mode field picks master rate, slave or I2C.
module ssp_port
    import ssp_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic [1:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [7:0]         reg_rdata,
    input  wire logic          sub_tick,
    input  wire logic          tmr_tick,
    input  wire ssp_pins_in_t  pins_in,
    output ssp_pins_out_t      pins_out,
    output logic               port_active,
    output logic               i2c_flags_clr
);
    logic [7:0]    ctrl0;
    logic [7:0]    ctrl2;
    logic [7:0]    shreg;
    logic [3:0]    bit_cnt;
    logic [4:0]    div_cnt;
    logic          cap_bit;
    ssp_state_t    state;
    ssp_pins_in_t  sync1;
    ssp_pins_in_t  sync2;
    logic          sck_q;
    logic          scs_q;

    wire ssp_mode_t mode    = ssp_mode_t'(ctrl0[C0_MODE_LSB +: 3]);
    wire logic en           = ctrl0[C0_EN];
    wire logic ckpol        = ctrl2[C2_CKPOL];
    wire logic capture_edge_select         = ctrl2[C2_CAPTURE_EDGE_SELECT];
    wire logic msb_first    = ctrl2[C2_MLS];
    wire logic select_pin_enable         = ctrl2[C2_SELECT_PIN_ENABLE];
    wire logic is_master    = (mode <= MODE_MTMR);
    wire logic is_slave     = (mode == MODE_SLV);
    wire logic spi_run      = en & (is_master | is_slave);
    wire logic idle_lvl     = ~ckpol;
    wire logic busy         = (state != ST_IDLE);

    // Capture edge: rising when polarity and edge bits are equal
    wire logic cap_rise     = ckpol ^ ~capture_edge_select;

    // Master half-period tick per selected clock source
    wire logic [4:0] half_lim =
        (mode == MODE_M4)  ? HALF_DIV4  :
        (mode == MODE_M16) ? HALF_DIV16 : HALF_DIV64;
    wire logic div_hit      = (div_cnt == half_lim);
    wire logic m_tick       =
        (mode == MODE_MSUB) ? sub_tick :
        (mode == MODE_MTMR) ? tmr_tick : div_hit;

    // Slave pin edges, read from second stage only
    wire logic sck_s        = sync2.sck_i;
    wire logic s_rise       = sck_s & ~sck_q;
    wire logic s_fall       = ~sck_s & sck_q;
    wire logic sel_act      = ~select_pin_enable | ~sync2.scs_n_i;
    wire logic scs_rise     = select_pin_enable & sync2.scs_n_i & ~scs_q;
    wire logic s_cap        = cap_rise ? s_rise : s_fall;
    wire logic s_sft        = cap_rise ? s_fall : s_rise;

    // Decoding of the register port
    wire logic wr_c0        = reg_wr & (reg_addr == REG_CTRL0);
    wire logic wr_c2        = reg_wr & (reg_addr == REG_CTRL2);
    wire logic wr_dat       = reg_wr & (reg_addr == REG_DATA);
    wire logic data_ok      = wr_dat & ~busy;
    wire logic collide      = wr_dat & busy & spi_run;
    wire logic en_rise      = wr_c0 & reg_wdata[C0_EN] & ~en;
    wire logic in_bit       = sync2.sdi_i;
    wire logic out_bit      = msb_first ? shreg[7] : shreg[0];

    // Master phases: lead half ends on capture, trail half shifts
    wire logic m_go         = is_master & spi_run & data_ok;
    wire logic do_cap       = busy & (is_master ?
                              (state == ST_LEAD & m_tick) :
                              (s_cap & sel_act));
    wire logic do_sft       = busy & (is_master ?
                              (state == ST_TRAIL & m_tick) :
                              (s_sft & sel_act & bit_cnt != 4'h0));
    wire logic last_bit     = (bit_cnt == BITS_PER_XFER - 4'h1);
    wire logic done_ev      = last_bit &
                              (is_master ? do_sft : do_cap);
    wire logic abort_ev     = is_slave & spi_run & busy &
                              scs_rise;
    wire logic [7:0] shifted = msb_first ?
        {shreg[6:0], cap_bit} : {cap_bit, shreg[7:1]};
    wire logic [7:0] cap_shift = msb_first ?
        {shreg[6:0], in_bit} : {in_bit, shreg[7:1]};
    // Master clock is active in the lead half with edge bit 0, in the trail half with edge bit 1
    wire logic m_sck_act    = is_master & spi_run &
                              ((state == ST_TRAIL & capture_edge_select) |
                               (state == ST_LEAD & ~capture_edge_select));

    wire logic [7:0] rd_mux =
        (reg_addr == REG_CTRL0) ? {ctrl0[7:5], 1'b0, ctrl0[3:0]} :
        (reg_addr == REG_CTRL2) ? ctrl2 :
        (reg_addr == REG_DATA)  ? shreg : 8'h00;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Preset to idle pin levels so no false select edge follows reset
            sync1 <= ssp_pins_in_t'(3'b001);
            sync2 <= ssp_pins_in_t'(3'b001);
            sck_q <= 1'b0;
            scs_q <= 1'b1;
        end else begin
            sync1 <= pins_in;
            sync2 <= sync1;
            sck_q <= sync2.sck_i;
            scs_q <= sync2.scs_n_i;
        end
    end

    // First control register; enable edge does not touch other bits
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0 <= C0_RESET;
        end else begin
            if (wr_c0) begin
                ctrl0 <= reg_wdata;
            end
            if (abort_ev) begin
                ctrl0[C0_ICF] <= 1'b1;
            end
        end
    end

    // Line control; hardware set wins over software clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl2 <= C2_RESET;
        end else begin
            if (wr_c2) begin
                ctrl2 <= reg_wdata;
            end
            if (collide) begin
                ctrl2[C2_WRITE_COLLISION_FLAG] <= 1'b1;
            end
            if (done_ev | abort_ev) begin
                ctrl2[C2_TRF] <= 1'b1;
            end
        end
    end

    // Shift engine
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= ST_IDLE;
            shreg   <= DATA_RESET;
            bit_cnt <= 4'h0;
            cap_bit <= 1'b0;
            div_cnt <= 5'h00;
        end else if (!spi_run) begin
            state   <= ST_IDLE;
            bit_cnt <= 4'h0;
            div_cnt <= 5'h00;
            if (data_ok) begin
                shreg <= reg_wdata;
            end
        end else begin
            div_cnt <= (div_hit | state == ST_IDLE) ? 5'h00 :
                       div_cnt + 5'h01;
            case (state)
                ST_IDLE: begin
                    bit_cnt <= 4'h0;
                    if (data_ok) begin
                        shreg <= reg_wdata;
                        state <= is_master ? ST_LEAD : ST_TRAIL;
                    end
                end
                ST_LEAD: begin
                    if (do_cap) begin
                        cap_bit <= in_bit;
                        state   <= ST_TRAIL;
                    end
                end
                default: begin
                    if (abort_ev) begin
                        state <= ST_IDLE;
                    end else if (do_cap) begin
                        cap_bit <= in_bit;
                        bit_cnt <= bit_cnt + 4'h1;
                        if (last_bit) begin
                            shreg <= cap_shift;
                            state <= ST_IDLE;
                        end
                    end else if (do_sft) begin
                        shreg   <= shifted;
                        if (is_master) begin
                            bit_cnt <= bit_cnt + 4'h1;
                            // Last trail half ends the byte
                            state   <= last_bit ? ST_IDLE : ST_LEAD;
                        end
                    end
                end
            endcase
        end
    end

    // Pin drive; enabled idle gives high data and polarity clock
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_out      <= '0;
            reg_rdata     <= 8'h00;
            port_active   <= 1'b0;
            i2c_flags_clr <= 1'b0;
        end else begin
            pins_out.sck_oe <= spi_run & is_master;
            pins_out.sck_o  <= m_sck_act ?
                               ~idle_lvl : idle_lvl;
            pins_out.sdo_oe <= spi_run & (is_master | sel_act);
            pins_out.sdo_o  <= busy ? out_bit : 1'b1;
            reg_rdata       <= reg_rd ? rd_mux : 8'h00;
            port_active     <= spi_run;
            i2c_flags_clr   <= en_rise &
                (reg_wdata[C0_MODE_LSB +: 3] == MODE_I2C);
        end
    end

    property p_collide;
        @(posedge sys_clk) disable iff (!rst_n)
        (collide && !do_sft && !done_ev) |=>
            ctrl2[C2_WRITE_COLLISION_FLAG] && $stable(shreg);
    endproperty
    a_collision_flag: assert property (p_collide)
        else $error("collision flag not set or data changed");

    sequence s_abort;
        abort_ev;
    endsequence
    a_abort_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_abort |=> ctrl0[C0_ICF] && ctrl2[C2_TRF] && !busy)
        else $error("abort did not set both flags");

    a_sw_icf_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_c0 && reg_wdata[C0_ICF] && !ctrl2[C2_TRF] && !abort_ev &&
         !done_ev && !wr_c2) |=> !ctrl2[C2_TRF])
        else $error("software flag write set done flag");

    a_done_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
        done_ev |=> ctrl2[C2_TRF] && state == ST_IDLE)
        else $error("done flag missing at byte end");

    a_idle_clock: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (spi_run && is_master && state == ST_IDLE) [*2]
        |-> pins_out.sck_o == ~ckpol)
        else $error("idle clock level wrong");

    a_master_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
        m_go |=> state == ST_LEAD)
        else $error("master write did not start");

    a_disable_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !spi_run |=> state == ST_IDLE && !pins_out.sck_oe)
        else $error("disabled port still running");

    a_byte_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
        busy |-> bit_cnt < BITS_PER_XFER)
        else $error("bit count past eight");

    a_gp_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_c2 |=> ctrl2[7:6] == $past(reg_wdata[7:6]))
        else $error("storage bits not kept");
endmodule : ssp_port
`default_nettype wire

// >>> ssp_peer.sv
/* SPI peer model: slave while the port is master, master otherwise.
   Assumes the bench sets role and line settings before arming it. */
`default_nettype none
module ssp_peer
    import ssp_pkg::*;
(
    input  wire logic          role_master,
    input  wire logic          pol,
    input  wire logic          edg,
    input  wire logic          msb,
    input  wire ssp_pins_out_t pins_out,
    output var  ssp_pins_in_t  pins_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] tx;
    logic [7:0] rx;
    int         caps;
    initial begin
        pins_in = 3'b001;
        caps = 0;
    end
    function automatic logic pick(input int i);
        pick = msb ? tx[7 - i] : tx[i];
    endfunction : pick
    task automatic arm(input logic [7:0] b);
        tx = b;
        caps = 0;
        pins_in.sck_i = ~pol;
        pins_in.sdi_i = pick(0);
    endtask : arm
    // Rising edge captures when polarity equals edge bit
    task automatic edge_evt(input logic lvl);
        if (lvl == (pol == edg)) begin
            rx = msb ? {rx[6:0], pins_out.sdo_o}
                     : {pins_out.sdo_o, rx[7:1]};
            caps++;
            // As slave, present the next bit right after capture
            if (!role_master && caps < 8) begin
                pins_in.sdi_i = pick(caps);
            end
        end else if (role_master && caps > 0 && caps < 8) begin
            pins_in.sdi_i = pick(caps);
        end
    endtask : edge_evt
    always @(pins_out.sck_o) begin
        if (!role_master) begin
            edge_evt(pins_out.sck_o);
        end
    end
    // Clock stands still outside the frame
    task automatic run(input int nbits);
        pins_in.scs_n_i = 1'b0;
        #250;
        for (int i = 0; i < 2 * nbits; i++) begin
            pins_in.sck_i = ~pins_in.sck_i;
            edge_evt(pins_in.sck_i);
            #62.5;
        end
        #250;
        pins_in.scs_n_i = 1'b1;
        pins_in.sdi_i = ~pins_in.sdi_i; // Released line shows no stale bit
    endtask : run
endmodule : ssp_peer
`default_nettype wire

// >>> ssp_port_tb_top.sv
/* Bench for the serial port: register tasks, read monitor, peer model.
   Assumes the package and the peer model are compiled first. */
`default_nettype none
module ssp_port_tb_top;
    import ssp_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
    logic          sys_clk = 1'b0;
    logic          rst_n = 1'b0;
    logic [1:0]    reg_addr = 2'h0;
    logic [7:0]    reg_wdata = 8'h00;
    logic          reg_wr = 1'b0;
    logic          reg_rd = 1'b0;
    logic [7:0]    reg_rdata;
    logic          sub_tick = 1'b0;
    logic          tmr_tick = 1'b0;
    ssp_pins_in_t  pins_in;
    ssp_pins_out_t pins_out;
    logic          port_active;
    logic          i2c_flags_clr;
    logic          role_master = 1'b0;
    logic          pol = 1'b0;
    logic          edg = 1'b0;
    logic          msb = 1'b0;
    logic [31:0]   seed = 32'hfe26;
    logic [7:0]    exp_q[$];
    logic [7:0]    want;
    logic          pend = 1'b0;
    int            mismatches = 0;
    int            checks = 0;
    int            clr_cnt = 0;
    logic [1:0]    ph = 2'h0;
    always #5 sys_clk = ~sys_clk;
    ssp_port dut (
        .sys_clk       (sys_clk),
        .rst_n         (rst_n),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .sub_tick      (sub_tick),
        .tmr_tick      (tmr_tick),
        .pins_in       (pins_in),
        .pins_out      (pins_out),
        .port_active   (port_active),
        .i2c_flags_clr (i2c_flags_clr)
    );
    ssp_peer peer (
        .role_master (role_master),
        .pol         (pol),
        .edg         (edg),
        .msb         (msb),
        .pins_out    (pins_out),
        .pins_in     (pins_in)
    );
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        xs = v ^ (v << 5);
    endfunction : xs
    task automatic results;
        if (mismatches == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    // Read data stand only in the cycle after the strobe
    always @(posedge sys_clk) begin
        seed = xs(seed);
        // Ticks spaced four cycles apart leave the pin synchroniser time
        ph <= ph + 2'h1;
        sub_tick <= (ph == 2'h0) & seed[3];
        tmr_tick <= (ph == 2'h2) & seed[9];
        if (i2c_flags_clr === 1'b1) clr_cnt++;
        if (pend) begin
            want = exp_q.pop_front();
            `CHK(reg_rdata, want)
        end
        pend = reg_rd;
    end
    // Gap cycle after each strobe keeps one assignment per step
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
    endtask : rd
    task automatic xfer(input logic [2:0] md, input logic [7:0] c2,
                        input int nb);
        logic [7:0] tx;
        logic [7:0] ptx;
        logic [7:0] on;
        tx = seed[7:0];
        ptx = seed[15:8];
        on = {md, 5'h02};
        role_master = (md == MODE_SLV);
        wr(REG_CTRL2, c2);
        wr(REG_CTRL0, on);
        rd(REG_CTRL2, c2);
        `CHK(port_active, 1'b1)
        `CHK(pins_out.sck_oe, ~role_master)
        if (!role_master) `CHK(pins_out.sck_o, ~pol)
        `CHK(pins_out.sdo_o, 1'b1)
        peer.arm(ptx);
        wr(REG_DATA, tx);
        if (role_master) peer.run(nb);
        else wr(REG_DATA, ~tx);
        for (int n = 0; n < 3000 && peer.caps < nb; n++) @(posedge sys_clk);
        repeat (80) @(posedge sys_clk);
        if (nb == 8) begin
            rd(REG_CTRL2, c2 | {6'h00, ~role_master, 1'b1});
            rd(REG_DATA, ptx);
            `CHK(peer.rx, tx)
        end else begin
            rd(REG_CTRL0, on | {7'h00, c2[2]});
            rd(REG_CTRL2, c2 | {7'h00, c2[2]});
        end
        wr(REG_CTRL2, c2);
        wr(REG_CTRL0, on | 8'h01);
        rd(REG_CTRL2, c2);
        wr(REG_CTRL0, {md, 5'h00});
        rd(REG_CTRL0, {md, 5'h00});
        `CHK({port_active, pins_out.sdo_oe}, 2'b00)
    endtask : xfer
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(REG_CTRL0, C0_RESET);
        rd(REG_CTRL2, C2_RESET);
        rd(REG_DATA, DATA_RESET);
        rd(2'h3, 8'h00);
        wr(REG_CTRL2, 8'hc0);
        rd(REG_CTRL2, 8'hc0);
        for (int i = 0; i < 10; i++) begin
            {msb, edg, pol} = 3'(i);
            xfer(3'(i % 5), {2'b00, pol, edg, msb, 3'b100}, 8);
        end
        for (int i = 0; i < 6; i++) begin
            {msb, edg, pol} = 3'(i);
            xfer(MODE_SLV, {2'b00, pol, edg, msb, i != 5, 2'b00},
                 i < 4 ? 8 : 5);
        end
        wr(REG_CTRL0, {MODE_I2C, 5'h00});
        wr(REG_CTRL0, {MODE_I2C, 5'h02});
        rd(REG_CTRL0, {MODE_I2C, 5'h02});
        `CHK(clr_cnt, 1)
        `CHK(port_active, 1'b0)
        results();
    end
    // Whole run needs well under a fifth of this span
    initial begin
        #400us;
        mismatches++;
        results();
    end
`undef CHK
endmodule : ssp_port_tb_top
`default_nettype wire
